// ===== pkg/gpio_ports_pkg.sv
// shared constants for the port e / port f general-purpose i/o block
package gpio_ports_pkg;

	// ------------------------------------------------------------
	// port widths
	// ------------------------------------------------------------
	localparam int PORT_E_WIDTH = 8;
	localparam int PORT_F_WIDTH = 4;

	// ------------------------------------------------------------
	// register map (byte addresses; index * 4 since 0x09 is not word aligned)
	// ------------------------------------------------------------
	localparam logic [11:0] PORT_E_DATA_INDEX      = 12'h008;
	localparam logic [11:0] PORT_F_DATA_INDEX      = 12'h009;
	localparam logic [11:0] PORT_E_DIRECTION_INDEX = 12'h00C;
	localparam logic [11:0] PORT_F_DIRECTION_INDEX = 12'h00D;
	localparam logic [11:0] PORT_E_DATA_ADDR       = 12'(PORT_E_DATA_INDEX * 4);
	localparam logic [11:0] PORT_F_DATA_ADDR       = 12'(PORT_F_DATA_INDEX * 4);
	localparam logic [11:0] PORT_E_DIRECTION_ADDR  = 12'(PORT_E_DIRECTION_INDEX * 4);
	localparam logic [11:0] PORT_F_DIRECTION_ADDR  = 12'(PORT_F_DIRECTION_INDEX * 4);

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  PORT_E_DIRECTION_RESET = 8'h00;
	localparam logic [3:0]  PORT_F_DIRECTION_RESET = 4'h0;
	localparam logic [7:0]  PORT_E_DATA_RESET      = 8'h00;
	localparam logic [31:0] READ_ZERO              = 32'h00000000;

	// ------------------------------------------------------------
	// synchroniser depth
	// ------------------------------------------------------------
	localparam int SYNC_STAGES = 2;

	// ------------------------------------------------------------
	// bus lanes
	// ------------------------------------------------------------
	// byte lane that carries every register bit
	localparam int DATA_LANE = 0;

endpackage : gpio_ports_pkg

// ===== logic/pin_sync.sv
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module pin_sync
	import gpio_ports_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// pin levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] pin_level,
	output logic      [WIDTH-1:0] synced_level
);

	typedef struct packed {
		logic [WIDTH-1:0] first_stage;
		logic [WIDTH-1:0] second_stage;
	} sync_state_type;

	sync_state_type state;
	sync_state_type next_state;

	// first stage feeds only the second stage
	always_comb begin
		next_state              = state;
		next_state.first_stage  = pin_level;
		next_state.second_stage = state.first_stage;
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign synced_level = state.second_stage;

endmodule : pin_sync

// ===== logic/port_bit_mux.sv
// per-port pin driver and read-source selection
`timescale 1ns/1ps
module port_bit_mux #(
	parameter int WIDTH = 8
) (
	// register contents
	input  wire logic [WIDTH-1:0] data_latch,
	input  wire logic [WIDTH-1:0] direction,
	// peripheral ownership and its drive
	input  wire logic [WIDTH-1:0] periph_owns,
	input  wire logic [WIDTH-1:0] periph_out,
	input  wire logic [WIDTH-1:0] periph_oe,
	// synchronised pin level
	input  wire logic [WIDTH-1:0] pin_synced,
	// pin drive and read value
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe,
	output logic      [WIDTH-1:0] read_value
);

	// a peripheral owning a pin takes its driver; direction still picks read source
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			pin_out[i]    = periph_owns[i] ? periph_out[i] : data_latch[i];
			pin_oe[i]     = periph_owns[i] ? periph_oe[i] : direction[i];
			read_value[i] = direction[i] ? data_latch[i] : pin_synced[i];
		end
	end

endmodule : port_bit_mux

// ===== logic/gpio_ports_e_f.sv
// port e and port f general-purpose i/o with apb register access
//
// Contract
// - port e direction bit one enables its pin driver, zero makes it input
// - reset clears all eight port e direction bits
// - port e data read returns latch for outputs, pin level for inputs
// - data writes always update latches and never alter input readback
// - four port f data latches, untouched by reset
// - port f direction bit one enables its pin driver, zero makes it input
// - reset clears all four port f direction bits
// - port f data read returns latch for outputs, pin level for inputs
// - timer-owned port f pin ignores direction for drive, not for read
// - peripheral-owned port e pin ignores direction for drive, not for read
// - port e data holds eight writable latches driven where enabled
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module gpio_ports_e_f
	import gpio_ports_pkg::*;
(
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// port e pins
	input  wire logic [PORT_E_WIDTH-1:0] port_e_pin_in,
	output logic      [PORT_E_WIDTH-1:0] port_e_pin_out,
	output logic      [PORT_E_WIDTH-1:0] port_e_pin_oe,
	// port e peripheral takeover (spi, serial_comm_interface, timer_module)
	input  wire logic [PORT_E_WIDTH-1:0] port_e_periph_owns,
	input  wire logic [PORT_E_WIDTH-1:0] port_e_periph_out,
	input  wire logic [PORT_E_WIDTH-1:0] port_e_periph_oe,
	// port f pins
	input  wire logic [PORT_F_WIDTH-1:0] port_f_pin_in,
	output logic      [PORT_F_WIDTH-1:0] port_f_pin_out,
	output logic      [PORT_F_WIDTH-1:0] port_f_pin_oe,
	// port f timer takeover, decoded from timer_edge_level_select
	input  wire logic [PORT_F_WIDTH-1:0] timer_channel_pins,
	input  wire logic [PORT_F_WIDTH-1:0] timer_pin_out,
	input  wire logic [PORT_F_WIDTH-1:0] timer_pin_oe
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [PORT_E_WIDTH-1:0] port_e_direction;
		logic [PORT_F_WIDTH-1:0] port_f_direction;
		logic [PORT_E_WIDTH-1:0] port_e_data;
		logic [31:0]             read_data;
	} regs_type;

	regs_type state;
	regs_type next_state;

	// port f latches live outside the reset struct: reset must not touch them
	logic [PORT_F_WIDTH-1:0] port_f_data;
	logic [PORT_F_WIDTH-1:0] next_port_f_data;

	// ------------------------------------------------------------
	// pin synchronisers and muxing
	// ------------------------------------------------------------
	logic [PORT_E_WIDTH-1:0] port_e_synced;
	logic [PORT_F_WIDTH-1:0] port_f_synced;
	logic [PORT_E_WIDTH-1:0] port_e_read;
	logic [PORT_F_WIDTH-1:0] port_f_read;

	// input levels resynchronised before readback
	pin_sync #(.WIDTH(PORT_E_WIDTH)) port_e_sync (
		.pclk         (pclk),
		.presetn      (presetn),
		.pin_level    (port_e_pin_in),
		.synced_level (port_e_synced)
	);

	pin_sync #(.WIDTH(PORT_F_WIDTH)) port_f_sync (
		.pclk         (pclk),
		.presetn      (presetn),
		.pin_level    (port_f_pin_in),
		.synced_level (port_f_synced)
	);

	// port e: driver from direction or peripheral, read by direction
	port_bit_mux #(.WIDTH(PORT_E_WIDTH)) port_e_mux (
		.data_latch  (state.port_e_data),
		.direction   (state.port_e_direction),
		.periph_owns (port_e_periph_owns),
		.periph_out  (port_e_periph_out),
		.periph_oe   (port_e_periph_oe),
		.pin_synced  (port_e_synced),
		.pin_out     (port_e_pin_out),
		.pin_oe      (port_e_pin_oe),
		.read_value  (port_e_read)
	);

	// port f: timer takes the driver only, read source stays on direction
	port_bit_mux #(.WIDTH(PORT_F_WIDTH)) port_f_mux (
		.data_latch  (port_f_data),
		.direction   (state.port_f_direction),
		.periph_owns (timer_channel_pins),
		.periph_out  (timer_pin_out),
		.periph_oe   (timer_pin_oe),
		.pin_synced  (port_f_synced),
		.pin_out     (port_f_pin_out),
		.pin_oe      (port_f_pin_oe),
		.read_value  (port_f_read)
	);

	// ------------------------------------------------------------
	// apb phase decode
	// ------------------------------------------------------------
	logic setup_phase;
	logic access_phase;
	logic read_setup;
	logic write_access;
	logic lane_enabled;

	// a read is captured in setup so the access phase answers at once
	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;
	assign read_setup   = setup_phase && !pwrite;
	assign write_access = access_phase && pwrite;

	// every register bit sits in the low byte lane; other lanes are ignored
	assign lane_enabled = pstrb[DATA_LANE];

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic hit_e_data;
	logic hit_f_data;
	logic hit_e_dir;
	logic hit_f_dir;
	logic addr_mapped;

	// full-width compare: no aliases, so a stray address cannot move a pin
	assign hit_e_data  = (paddr == PORT_E_DATA_ADDR);
	assign hit_f_data  = (paddr == PORT_F_DATA_ADDR);
	assign hit_e_dir   = (paddr == PORT_E_DIRECTION_ADDR);
	assign hit_f_dir   = (paddr == PORT_F_DIRECTION_ADDR);

	// any of the four registers
	assign addr_mapped = hit_e_data || hit_f_data || hit_e_dir || hit_f_dir;

	// ------------------------------------------------------------
	// write strobes
	// ------------------------------------------------------------
	logic write_e_data;
	logic write_f_data;
	logic write_e_dir;
	logic write_f_dir;

	// data latches take writes whatever the direction
	assign write_e_data = write_access && lane_enabled && hit_e_data;
	assign write_f_data = write_access && lane_enabled && hit_f_data;

	// direction writes; software loads the latch first to avoid a glitch
	assign write_e_dir  = write_access && lane_enabled && hit_e_dir;
	assign write_f_dir  = write_access && lane_enabled && hit_f_dir;

	// ------------------------------------------------------------
	// write data
	// ------------------------------------------------------------
	logic [PORT_E_WIDTH-1:0] write_e_bits;
	logic [PORT_F_WIDTH-1:0] write_f_bits;

	// upper lanes dropped on purpose: no register bit lives there
	assign write_e_bits = pwdata[PORT_E_WIDTH-1:0];
	assign write_f_bits = pwdata[PORT_F_WIDTH-1:0];

	// ------------------------------------------------------------
	// read words
	// ------------------------------------------------------------
	logic [31:0] e_data_word;
	logic [31:0] f_data_word;
	logic [31:0] e_dir_word;
	logic [31:0] f_dir_word;
	logic [31:0] read_word;

	// port e data image: latch or pin per direction bit
	always_comb begin
		e_data_word                   = READ_ZERO;
		e_data_word[PORT_E_WIDTH-1:0] = port_e_read;
	end

	// port f data image: latch or pin per direction bit
	always_comb begin
		f_data_word                   = READ_ZERO;
		f_data_word[PORT_F_WIDTH-1:0] = port_f_read;
	end

	// port e direction reads back as written
	always_comb begin
		e_dir_word                   = READ_ZERO;
		e_dir_word[PORT_E_WIDTH-1:0] = state.port_e_direction;
	end

	// port f direction; upper bits of every image read as zero
	always_comb begin
		f_dir_word                   = READ_ZERO;
		f_dir_word[PORT_F_WIDTH-1:0] = state.port_f_direction;
	end

	// ------------------------------------------------------------
	// read select
	// ------------------------------------------------------------
	// unmapped reads return zero alongside the error response
	always_comb begin
		if (hit_e_data) begin
			read_word = e_data_word;
		end else if (hit_f_data) begin
			read_word = f_data_word;
		end else if (hit_e_dir) begin
			read_word = e_dir_word;
		end else if (hit_f_dir) begin
			read_word = f_dir_word;
		end else begin
			read_word = READ_ZERO;
		end
	end

	// ------------------------------------------------------------
	// bus response
	// ------------------------------------------------------------
	// zero wait states: every access completes in its first cycle
	assign pready  = 1'b1;

	// error only while the access phase of an unmapped address stands
	assign pslverr = access_phase && !addr_mapped;

	// read data from a register, stable from its setup edge to the next read
	assign prdata  = state.read_data;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_state       = state;
		next_port_f_data = port_f_data;

		// port e latches, written whatever the direction
		if (write_e_data) begin
			next_state.port_e_data = write_e_bits;
		end

		// port f latches; the pin input path is never touched
		if (write_f_data) begin
			next_port_f_data = write_f_bits;
		end

		// port e direction
		if (write_e_dir) begin
			next_state.port_e_direction = write_e_bits;
		end

		// port f direction
		if (write_f_dir) begin
			next_state.port_f_direction = write_f_bits;
		end

		// read value sampled in setup, held through access and beyond
		if (read_setup) begin
			next_state.read_data = read_word;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// directions cleared so every pin not owned by a peripheral or the timer starts as an input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.port_e_direction <= PORT_E_DIRECTION_RESET;
			state.port_f_direction <= PORT_F_DIRECTION_RESET;
			state.port_e_data      <= PORT_E_DATA_RESET;
			state.read_data        <= READ_ZERO;
		end else begin
			state <= next_state;
		end
	end

	// no reset term: latch contents survive reset
	always_ff @(posedge pclk) begin
		port_f_data <= next_port_f_data;
	end

endmodule : gpio_ports_e_f

// ===== verification/gpio_ports_e_f_checker.sv
// concurrent checks on the port e / port f block
`timescale 1ns/1ps
module gpio_ports_e_f_checker
	import gpio_ports_pkg::*;
(
	// apb side
	input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0]  pstrb,
	// pins and takeover
	input wire logic [7:0]  port_e_pin_out, port_e_pin_oe, port_e_periph_owns, port_e_periph_out, port_e_periph_oe,
	input wire logic [3:0]  port_f_pin_out, port_f_pin_oe, timer_channel_pins, timer_pin_out, timer_pin_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// pready is tied high, so every write access edge with pstrb[0] set commits its write
	logic       wr;
	logic       mapped;
	logic [7:0] wd;
	logic [3:0] wf;
	assign wr = psel && penable && pwrite && pstrb[0];
	assign mapped = paddr inside {PORT_E_DATA_ADDR, PORT_F_DATA_ADDR, PORT_E_DIRECTION_ADDR, PORT_F_DIRECTION_ADDR};
	assign wd = pwdata[7:0];
	assign wf = pwdata[3:0];

	e_dir_a: assert property (wr && paddr == PORT_E_DIRECTION_ADDR |=>
		((port_e_pin_oe ^ $past(wd)) & ~port_e_periph_owns) == 8'h00) else $error("port e enable wrong");
	f_dir_a: assert property (wr && paddr == PORT_F_DIRECTION_ADDR |=>
		((port_f_pin_oe ^ $past(wf)) & ~timer_channel_pins) == 4'h0) else $error("port f enable wrong");
	e_latch_a: assert property (wr && paddr == PORT_E_DATA_ADDR |=>
		((port_e_pin_out ^ $past(wd)) & ~port_e_periph_owns) == 8'h00) else $error("port e latch wrong");
	f_latch_a: assert property (wr && paddr == PORT_F_DATA_ADDR |=>
		((port_f_pin_out ^ $past(wf)) & ~timer_channel_pins) == 4'h0) else $error("port f latch wrong");
	e_owner_a: assert property ((((port_e_pin_oe ^ port_e_periph_oe) |
		(port_e_pin_out ^ port_e_periph_out)) & port_e_periph_owns) == 8'h00) else $error("port e owner drive");
	f_owner_a: assert property ((((port_f_pin_oe ^ timer_pin_oe) |
		(port_f_pin_out ^ timer_pin_out)) & timer_channel_pins) == 4'h0) else $error("port f owner drive");
	dir_reset_a: assert property ($rose(presetn) |-> ((port_e_pin_oe & ~port_e_periph_owns) == 8'h00) &&
		((port_f_pin_oe & ~timer_channel_pins) == 4'h0)) else $error("drivers on after reset");
	bus_answer_a: assert property (psel && penable |-> pready && (pslverr == !mapped))
		else $error("bus answer wrong");
	unmapped_zero_a: assert property (psel && !penable && !pwrite && !mapped |=> prdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule : gpio_ports_e_f_checker

bind gpio_ports_e_f gpio_ports_e_f_checker chk (.*);

// ===== verification/board_pins.sv
// board model: resolves each shared pin from the block's drive and the board level
`timescale 1ns/1ps
module board_pins (
	// block drive and board levels
	input  wire logic [7:0] e_out, e_oe, e_ext,
	input  wire logic [3:0] f_out, f_oe, f_ext,
	// resolved levels back to the block
	output logic      [7:0] e_level,
	output logic      [3:0] f_level
);
	// a driven pin follows the block, an undriven one the board
	assign e_level = (e_oe & e_out) | (~e_oe & e_ext);
	assign f_level = (f_oe & f_out) | (~f_oe & f_ext);
endmodule : board_pins

// ===== verification/tb_gpio_ports_e_f.sv
// self-checking bench for the port e / port f block
`timescale 1ns/1ps
module tb_gpio_ports_e_f import gpio_ports_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, seed, exp_v;
	logic [3:0]  pstrb, port_f_pin_in, port_f_pin_out, port_f_pin_oe, timer_channel_pins, timer_pin_out, timer_pin_oe;
	logic [7:0]  port_e_pin_in, port_e_pin_out, port_e_pin_oe, port_e_periph_owns, port_e_periph_out, port_e_periph_oe;
	logic [7:0]  ext_e, lat_e, dir_e;
	logic [3:0]  ext_f, lat_f, dir_f;
	logic [31:0] notes[$];
	int          err_total, tests_run;

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	gpio_ports_e_f dut (.*);
	board_pins board (.e_out(port_e_pin_out), .e_oe(port_e_pin_oe), .e_ext(ext_e), .f_out(port_f_pin_out),
		.f_oe(port_f_pin_oe), .f_ext(ext_f), .e_level(port_e_pin_in), .f_level(port_f_pin_in));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// read source: latch where direction is out, else the resolved pin level
	function automatic logic [7:0] pick(input logic [7:0] lat, dir, own, po, poe, ext);
		logic [7:0] oe;
		oe = (own & poe) | (~own & dir);
		return (dir & lat) | (~dir & ((oe & ((own & po) | (~own & lat))) | (~oe & ext)));
	endfunction : pick

	task automatic wrap_up();
		if (err_total == 0 && tests_run > 0 && notes.size() == 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	// one setup and access cycle; a stuck pready ends the run
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 64) begin
			err_total++;
			wrap_up();
		end
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		notes.push_back(e);
		apb(1'b0, a, 32'h00000000);
	endtask : rd

	// the oldest note is matched against each completed read
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			exp_v = notes.pop_front();
			tests_run++;
			if (prdata !== exp_v) begin
				err_total++;
				$display("[ERR] t=%0t got=%h exp=%h", $time, prdata, exp_v);
			end
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, ext_e, ext_f} = '0;
		{port_e_periph_owns, port_e_periph_out, port_e_periph_oe, timer_channel_pins, timer_pin_out, timer_pin_oe} = '0;
		pstrb = 4'hF;
		err_total = 0;
		tests_run = 0;
		seed = 32'hC747;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(PORT_E_DIRECTION_ADDR, 32'h00000000);
		rd(PORT_F_DIRECTION_ADDR, 32'h00000000);
		rd(12'h040, 32'h00000000);
		// random latches, directions, board levels and takeovers
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			{lat_e, dir_e} = seed[15:0];
			ext_e <= seed[23:16];
			port_e_periph_owns <= seed[31:24];
			seed = lfsr(seed);
			port_e_periph_out <= seed[7:0];
			port_e_periph_oe <= seed[15:8];
			{lat_f, dir_f} = seed[23:16];
			ext_f <= seed[27:24];
			timer_channel_pins <= seed[31:28];
			seed = lfsr(seed);
			timer_pin_out <= seed[3:0];
			timer_pin_oe <= seed[7:4];
			apb(1'b1, PORT_E_DATA_ADDR, {seed[31:8], lat_e});
			apb(1'b1, PORT_F_DATA_ADDR, {24'h0, seed[11:8], lat_f});
			apb(1'b1, PORT_E_DIRECTION_ADDR, {24'h0, dir_e});
			apb(1'b1, PORT_F_DIRECTION_ADDR, {28'h0, dir_f});
			repeat (3) @(posedge pclk);
			rd(PORT_E_DATA_ADDR, {24'h0, pick(lat_e, dir_e, port_e_periph_owns, port_e_periph_out,
				port_e_periph_oe, ext_e)});
			rd(PORT_F_DATA_ADDR, {24'h0, pick({4'h0, lat_f}, {4'h0, dir_f}, {4'h0, timer_channel_pins},
				{4'h0, timer_pin_out}, {4'h0, timer_pin_oe}, {4'h0, ext_f})});
			rd(PORT_F_DIRECTION_ADDR, {28'h0, dir_f});
		end
		// a write without its byte strobe leaves the register alone
		pstrb <= 4'h0;
		apb(1'b1, PORT_E_DIRECTION_ADDR, ~{24'h0, dir_e});
		pstrb <= 4'hF;
		rd(PORT_E_DIRECTION_ADDR, {24'h0, dir_e});
		// second reset: directions clear, port f latches survive
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(PORT_E_DIRECTION_ADDR, 32'h00000000);
		rd(PORT_F_DIRECTION_ADDR, 32'h00000000);
		apb(1'b1, PORT_F_DIRECTION_ADDR, 32'h0000000F);
		rd(PORT_F_DATA_ADDR, {28'h0, lat_f});
		// let the monitor take the last read before the verdict
		@(posedge pclk);
		wrap_up();
	end
endmodule : tb_gpio_ports_e_f
